// File: bridge_ctl_pkg.sv
// shared types and constants of the bridge command control block
package bridge_ctl_pkg;

  localparam logic [7:0] CMD_GLOBAL_RESET = 8'hF0;
  localparam logic [7:0] CMD_SET_POINTER = 8'hE1;
  localparam logic [7:0] CMD_WRITE_FEATURES = 8'hD2;

  localparam logic [7:0] PTR_FEATURES = 8'hC3;
  localparam logic [7:0] PTR_CONDITION = 8'hF0;
  localparam logic [7:0] PTR_RECEIVED = 8'hE1;
  localparam logic [7:0] PTR_PORT = 8'hB4;

  localparam int CLOCK_PS = 4000;
  localparam int RESET_MAX_PS = 525000;
  localparam int ABORT_MAX_PS = 262500;
  localparam int RESET_MAX_CYC = RESET_MAX_PS / CLOCK_PS;
  localparam int ABORT_MAX_CYC = ABORT_MAX_PS / CLOCK_PS;

  localparam int SYNC_STAGES = 3;
  localparam int PORT_ENTRIES = 8;
  localparam logic [2:0] PORT_IDX_RESET = 3'h0;
  localparam logic [3:0] PORT_CODE_DEFAULT = 4'h6;

  typedef enum logic [1:0]
  {
    SEL_CONDITION = 2'h0,
    SEL_FEATURES = 2'h1,
    SEL_RECEIVED = 2'h2,
    SEL_PORT = 2'h3
  } rd_sel_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CODE_ACK = 2'b01,
    ST_PARAM = 2'b11,
    ST_PARAM_ACK = 2'b10
  } fsm_t;

  typedef struct packed {
    logic branch_taken;
    logic second_search_bit;
    logic single_bit_result;
    logic reset_seen;
    logic line_level;
    logic short_found;
    logic presence_seen;
    logic line_busy;
  } cond_t;

  localparam cond_t COND_RESET = 8'h10;

  typedef struct packed {
    logic overdrive_speed;
    logic strong_pullup;
    logic line_power_down;
    logic active_pullup;
  } feat_t;

  localparam feat_t FEAT_RESET = 4'h0;

  typedef struct packed {
    logic [3:0] reset_low_std;
    logic [3:0] reset_low_od;
    logic [3:0] presence_sample_std;
    logic [3:0] presence_sample_od;
    logic [3:0] write_zero_low_std;
    logic [3:0] write_zero_low_od;
    logic [3:0] recovery;
    logic [3:0] weak_pullup;
  } port_t;

  localparam port_t PORT_RESET = {PORT_ENTRIES{PORT_CODE_DEFAULT}};

  typedef struct packed {
    logic presence_seen;
    logic short_found;
    logic single_bit_result;
    logic second_search_bit;
    logic branch_taken;
    logic [7:0] received;
  } seq_result_t;

endpackage : bridge_ctl_pkg

// File: pin_sync.sv
// three-stage synchroniser with edge detection for an outside pin
`timescale 1ns/1ps
module pin_sync
#(
  parameter int STAGES = 3
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic [STAGES-1:0] sh;
    logic level;
  } sync_t;

  sync_t s_q;
  sync_t s_d;
  logic agree;

  // last two stages must agree so a metastable first stage never counts
  always_comb
  begin
    s_d = s_q;
    s_d.sh = {s_q.sh[STAGES-2:0], pin};
    agree = (s_q.sh[STAGES-1] == s_q.sh[STAGES-2]);
    if (agree)
    begin
      s_d.level = s_q.sh[STAGES-1];
    end
    rise = agree && s_q.sh[STAGES-1] && !s_q.level;
    fall = agree && !s_q.sh[STAGES-1] && s_q.level;
    level = s_q.level;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '{sh: {STAGES{1'b1}}, level: 1'b1};
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : pin_sync

// File: bridge_command_control.sv
// device-control command decoder: global reset, read pointer, feature write
//
// Function
// - code F0h resets all state but the received byte and read data, aborts line activity, accepted any time
// - global reset completes within 525 ns of command ack falling edge
// - line activity stops within 262.5 ns of command ack falling edge
// - global reset points the read pointer at the condition register
// - global reset sets reset flag, clears busy and all result flags
// - global reset clears the four feature flags
// - global reset restores default port timing and pullup codes
// - code E1h plus pointer byte selects the register to read
// - pointer codes C3h features, F0h condition, E1h received, B4h port
// - pointer command overrides pointer set by a running line command
// - unknown pointer byte is not acknowledged and the command ignored
// - pointer updates on ack rising edge, line activity untouched
// - code D2h byte accepted only when upper nibble inverts lower nibble
// - features read back with upper nibble zero
// - D2h while line busy: neither code nor byte acknowledged, dropped
// - features load on ack rising edge and act at once
// - after feature write the pointer selects the features register
// - feature write changes only the four feature flags, reset flag and pointer
// - feature write clears the reset flag
// - busy flag is one while a line transfer runs, zero after
`timescale 1ns/1ps
module bridge_command_control
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl,
  input wire logic byte_valid,
  input wire logic byte_first,
  input wire logic [7:0] byte_data,
  input wire logic rd_req,
  input wire logic seq_busy,
  input wire logic seq_done,
  input wire bridge_ctl_pkg::seq_result_t seq_result,
  input wire logic seq_ptr_valid,
  input wire bridge_ctl_pkg::rd_sel_t seq_ptr_sel,
  output logic ack,
  output logic line_abort,
  output bridge_ctl_pkg::feat_t features,
  output bridge_ctl_pkg::port_t port_timing,
  output bridge_ctl_pkg::rd_sel_t rd_ptr,
  output logic [7:0] rd_data
);

  typedef struct packed {
    bridge_ctl_pkg::fsm_t fsm;
    logic [7:0] code;
    logic [7:0] param;
    logic ack;
    logic abort;
    bridge_ctl_pkg::cond_t cond;
    bridge_ctl_pkg::feat_t feat;
    bridge_ctl_pkg::port_t port;
    bridge_ctl_pkg::rd_sel_t ptr;
    logic [2:0] port_idx;
    logic [7:0] received;
    logic [7:0] rd_data;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{
    fsm: bridge_ctl_pkg::ST_IDLE,
    code: 8'h00,
    param: 8'h00,
    ack: 1'b0,
    abort: 1'b0,
    cond: bridge_ctl_pkg::COND_RESET,
    feat: bridge_ctl_pkg::FEAT_RESET,
    port: bridge_ctl_pkg::PORT_RESET,
    ptr: bridge_ctl_pkg::SEL_CONDITION,
    port_idx: bridge_ctl_pkg::PORT_IDX_RESET,
    received: 8'h00,
    rd_data: 8'h00
  };

  ctl_t s_q;
  ctl_t s_d;
  logic scl_level;
  logic scl_rise;
  logic scl_fall;
  logic [2:0] ptr_dec;
  logic [2:0] byte_dec;

  // {valid, select} for a pointer byte
  function automatic logic [2:0] ptr_decode(input logic [7:0] c);
    logic [2:0] r;
    r = 3'h0;
    unique case (c)
      bridge_ctl_pkg::PTR_FEATURES: r = {1'b1, bridge_ctl_pkg::SEL_FEATURES};
      bridge_ctl_pkg::PTR_CONDITION: r = {1'b1, bridge_ctl_pkg::SEL_CONDITION};
      bridge_ctl_pkg::PTR_RECEIVED: r = {1'b1, bridge_ctl_pkg::SEL_RECEIVED};
      bridge_ctl_pkg::PTR_PORT: r = {1'b1, bridge_ctl_pkg::SEL_PORT};
      default: r = 3'h0;
    endcase
    return r;
  endfunction : ptr_decode

  function automatic logic nibble_ok(input logic [7:0] c);
    return c[7:4] == ~c[3:0];
  endfunction : nibble_ok

  // readback order of the port codes, rolling over after the last
  function automatic logic [3:0] port_pick(input bridge_ctl_pkg::port_t p, input logic [2:0] i);
    logic [31:0] flat;
    flat = p;
    return flat[(3'h7 - i) * 4 +: 4];
  endfunction : port_pick

  pin_sync
  #(
    .STAGES(bridge_ctl_pkg::SYNC_STAGES)
  )
  u_scl_sync
  (
    .clock(clock),
    .rstn(rstn),
    .pin(scl),
    .level(scl_level),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  always_comb
  begin
    s_d = s_q;
    ptr_dec = ptr_decode(s_q.param);
    byte_dec = ptr_decode(byte_data);
    s_d.abort = 1'b0;
    s_d.cond.line_busy = seq_busy;
    if (seq_done)
    begin
      s_d.cond.presence_seen = seq_result.presence_seen;
      s_d.cond.short_found = seq_result.short_found;
      s_d.cond.single_bit_result = seq_result.single_bit_result;
      s_d.cond.second_search_bit = seq_result.second_search_bit;
      s_d.cond.branch_taken = seq_result.branch_taken;
      s_d.received = seq_result.received;
    end
    // later assignments below win, so a pointer command overrides this
    if (seq_ptr_valid)
    begin
      s_d.ptr = seq_ptr_sel;
    end
    if (rd_req)
    begin
      unique case (s_q.ptr)
        bridge_ctl_pkg::SEL_CONDITION: s_d.rd_data = s_q.cond;
        bridge_ctl_pkg::SEL_FEATURES: s_d.rd_data = {4'h0, s_q.feat};
        bridge_ctl_pkg::SEL_RECEIVED: s_d.rd_data = s_q.received;
        bridge_ctl_pkg::SEL_PORT:
        begin
          s_d.rd_data = {4'h0, port_pick(s_q.port, s_q.port_idx)};
          s_d.port_idx = s_q.port_idx + 3'h1;
        end
      endcase
    end
    // ack bit ends on its falling edge
    if (scl_fall)
    begin
      s_d.ack = 1'b0;
    end
    unique case (s_q.fsm)
      bridge_ctl_pkg::ST_IDLE:
      begin
        s_d.fsm = bridge_ctl_pkg::ST_IDLE;
      end
      bridge_ctl_pkg::ST_CODE_ACK:
      begin
        if (scl_fall)
        begin
          if (s_q.code == bridge_ctl_pkg::CMD_GLOBAL_RESET)
          begin
            // one cycle after the edge is seen; well inside both limits
            s_d = CTL_RESET;
            s_d.received = s_q.received;
            s_d.rd_data = s_q.rd_data;
            s_d.abort = 1'b1;
          end
          else
          begin
            s_d.fsm = bridge_ctl_pkg::ST_PARAM;
          end
        end
      end
      bridge_ctl_pkg::ST_PARAM:
      begin
        if (byte_valid && !byte_first)
        begin
          s_d.param = byte_data;
          s_d.fsm = bridge_ctl_pkg::ST_PARAM_ACK;
          if (s_q.code == bridge_ctl_pkg::CMD_SET_POINTER)
          begin
            s_d.ack = byte_dec[2];
          end
          else
          begin
            s_d.ack = nibble_ok(byte_data);
          end
          if (!s_d.ack)
          begin
            s_d.fsm = bridge_ctl_pkg::ST_IDLE;
          end
        end
      end
      bridge_ctl_pkg::ST_PARAM_ACK:
      begin
        if (scl_rise)
        begin
          s_d.fsm = bridge_ctl_pkg::ST_IDLE;
          if (s_q.code == bridge_ctl_pkg::CMD_SET_POINTER)
          begin
            s_d.ptr = bridge_ctl_pkg::rd_sel_t'(ptr_dec[1:0]);
            s_d.port_idx = bridge_ctl_pkg::PORT_IDX_RESET;
          end
          else
          begin
            s_d.feat = s_q.param[3:0];
            s_d.cond.reset_seen = 1'b0;
            s_d.ptr = bridge_ctl_pkg::SEL_FEATURES;
          end
        end
      end
    endcase
    // a new command byte always restarts the decoder
    if (byte_valid && byte_first)
    begin
      s_d.code = byte_data;
      s_d.ack = 1'b0;
      s_d.fsm = bridge_ctl_pkg::ST_IDLE;
      unique case (byte_data)
        bridge_ctl_pkg::CMD_GLOBAL_RESET, bridge_ctl_pkg::CMD_SET_POINTER:
        begin
          s_d.ack = 1'b1;
          s_d.fsm = bridge_ctl_pkg::ST_CODE_ACK;
        end
        bridge_ctl_pkg::CMD_WRITE_FEATURES:
        begin
          // busy: no ack now, and idle state leaves the byte unacked too
          if (!s_q.cond.line_busy)
          begin
            s_d.ack = 1'b1;
            s_d.fsm = bridge_ctl_pkg::ST_CODE_ACK;
          end
        end
        default:
        begin
          s_d.ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= CTL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    ack = s_q.ack;
    line_abort = s_q.abort;
    features = s_q.feat;
    port_timing = s_q.port;
    rd_ptr = s_q.ptr;
    rd_data = s_q.rd_data;
  end

  localparam int ABORT_LIM = bridge_ctl_pkg::ABORT_MAX_CYC;
  localparam int RESET_LIM = bridge_ctl_pkg::RESET_MAX_CYC;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_reset_edge;
    s_q.fsm == bridge_ctl_pkg::ST_CODE_ACK && s_q.code == bridge_ctl_pkg::CMD_GLOBAL_RESET && scl_fall;
  endsequence

  sequence s_defaults;
    s_q.ptr == bridge_ctl_pkg::SEL_CONDITION && s_q.feat == bridge_ctl_pkg::FEAT_RESET
      && s_q.port == bridge_ctl_pkg::PORT_RESET && s_q.cond.reset_seen;
  endsequence

  sequence s_param_apply(logic [7:0] c);
    s_q.fsm == bridge_ctl_pkg::ST_PARAM_ACK && s_q.code == c && scl_rise;
  endsequence

  property p_abort_time;
    s_reset_edge |-> ##[1:ABORT_LIM] line_abort;
  endproperty
  a_abort_time: assert property (p_abort_time) else $error("abort late");

  property p_reset_time;
    s_reset_edge |-> ##[1:RESET_LIM] s_defaults;
  endproperty
  a_reset_time: assert property (p_reset_time) else $error("reset late");

  property p_reset_flags;
    line_abort |-> s_q.cond[7:5] == 3'h0 && s_q.cond[2:1] == 2'h0 && s_q.cond.reset_seen && !s_q.cond.line_busy;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags wrong");

  property p_ptr_set;
    s_param_apply(bridge_ctl_pkg::CMD_SET_POINTER) |=> rd_ptr == $past(ptr_dec[1:0]);
  endproperty
  a_ptr_set: assert property (p_ptr_set) else $error("pointer not set");

  property p_ptr_bad;
    s_q.fsm == bridge_ctl_pkg::ST_PARAM && s_q.code == bridge_ctl_pkg::CMD_SET_POINTER && byte_valid
      && !byte_first && !byte_dec[2] && !seq_ptr_valid
      |=> !ack && $stable(rd_ptr) && s_q.fsm == bridge_ctl_pkg::ST_IDLE;
  endproperty
  a_ptr_bad: assert property (p_ptr_bad) else $error("bad pointer taken");

  property p_feat_write;
    s_param_apply(bridge_ctl_pkg::CMD_WRITE_FEATURES)
      |=> features == $past(s_q.param[3:0]) && !s_q.cond.reset_seen && rd_ptr == bridge_ctl_pkg::SEL_FEATURES;
  endproperty
  a_feat_write: assert property (p_feat_write) else $error("feature write");

  property p_feat_bad;
    s_q.fsm == bridge_ctl_pkg::ST_PARAM && s_q.code == bridge_ctl_pkg::CMD_WRITE_FEATURES
      && byte_valid && !byte_first && !nibble_ok(byte_data)
      |=> !ack ##1 $stable(features) [*2];
  endproperty
  a_feat_bad: assert property (p_feat_bad) else $error("bad byte taken");

  property p_busy_refuse;
    byte_valid && byte_first && byte_data == bridge_ctl_pkg::CMD_WRITE_FEATURES && s_q.cond.line_busy
      |=> !ack && s_q.fsm == bridge_ctl_pkg::ST_IDLE;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("busy write acked");

  property p_feat_read;
    rd_req && rd_ptr == bridge_ctl_pkg::SEL_FEATURES |=> rd_data == {4'h0, $past(features)};
  endproperty
  a_feat_read: assert property (p_feat_read) else $error("feature readback");

  property p_busy_follow;
    // the global reset cycle clears busy whatever the sequencer says
    seq_busy && !line_abort
      && !(s_q.fsm == bridge_ctl_pkg::ST_CODE_ACK && s_q.code == bridge_ctl_pkg::CMD_GLOBAL_RESET && scl_fall)
      |=> s_q.cond.line_busy;
  endproperty
  a_busy_follow: assert property (p_busy_follow) else $error("busy lost");

endmodule : bridge_command_control

// File: host_model.sv
// host side model: serial clock, command bytes and read requests
`timescale 1ns/1ps
module host_model
(
  input wire logic clock,
  input wire logic ack,
  input wire logic [7:0] rd_data,
  output logic scl,
  output logic byte_valid,
  output logic byte_first,
  output logic [7:0] byte_data,
  output logic rd_req
);
  // half of the 160 ns link period in 4 ns cycles
  localparam int HALF = 20;

  initial
  begin
    scl = 1'b1;
    byte_valid = 1'b0;
    byte_first = 1'b0;
    byte_data = 8'h00;
    rd_req = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // serial clock only runs inside a frame and rests high
  task automatic send(input logic first, input logic [7:0] data, output logic acked);
    for (int i = 0; i < 8; i++)
    begin
      scl = 1'b0;
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
    end
    scl = 1'b0;
    tick(4);
    byte_valid = 1'b1;
    byte_first = first;
    byte_data = data;
    tick(1);
    byte_valid = 1'b0;
    // no stale byte left on the lines once taken
    byte_data = ~data;
    tick(HALF - 5);
    acked = ack;
    scl = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
  endtask : send

  task automatic read(output logic [7:0] d);
    rd_req = 1'b1;
    tick(1);
    rd_req = 1'b0;
    tick(1);
    d = rd_data;
  endtask : read
endmodule : host_model

// File: bridge_command_control_test.sv
// self-checking bench for the bridge command control block
`timescale 1ns/1ps
module bridge_command_control_test;
  logic clock;
  logic rstn;
  logic scl;
  logic byte_valid;
  logic byte_first;
  logic [7:0] byte_data;
  logic rd_req;
  logic seq_busy;
  logic busy_req;
  logic busy_cut = 1'b0;
  logic seq_done;
  bridge_ctl_pkg::seq_result_t seq_result;
  logic seq_ptr_valid;
  bridge_ctl_pkg::rd_sel_t seq_ptr_sel;
  logic ack;
  logic line_abort;
  bridge_ctl_pkg::feat_t features;
  bridge_ctl_pkg::port_t port_timing;
  bridge_ctl_pkg::rd_sel_t rd_ptr;
  logic [7:0] rd_data;
  int n_errors = 0;
  int comparisons = 0;
  int n_abort = 0;
  realtime fall_ns = 0.0;
  realtime abort_ns = 0.0;
  logic a;
  logic [7:0] codes [4];
  bridge_ctl_pkg::rd_sel_t sels [4];

  bridge_command_control uut
  (
    .clock(clock), .rstn(rstn), .scl(scl), .byte_valid(byte_valid), .byte_first(byte_first),
    .byte_data(byte_data), .rd_req(rd_req), .seq_busy(seq_busy), .seq_done(seq_done),
    .seq_result(seq_result), .seq_ptr_valid(seq_ptr_valid), .seq_ptr_sel(seq_ptr_sel), .ack(ack),
    .line_abort(line_abort), .features(features), .port_timing(port_timing), .rd_ptr(rd_ptr),
    .rd_data(rd_data)
  );

  host_model host
  (
    .clock(clock), .ack(ack), .rd_data(rd_data), .scl(scl), .byte_valid(byte_valid),
    .byte_first(byte_first), .byte_data(byte_data), .rd_req(rd_req)
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(negedge scl) fall_ns = $realtime;

  // sequencer side drops busy at the clock falling edge inside the abort pulse, until its own request ends
  assign seq_busy = busy_req && !busy_cut;

  always @(negedge clock)
  begin
    busy_cut <= (line_abort === 1'b1) || (busy_cut && busy_req);
    if (line_abort === 1'b1)
    begin
      n_abort <= n_abort + 1;
      abort_ns <= $realtime - fall_ns;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic cmd(input logic [7:0] c, input logic [7:0] p, input logic ec, input logic ep);
    host.send(1'b1, c, a);
    check("code ack", {31'h0, a}, {31'h0, ec});
    host.send(1'b0, p, a);
    check("param ack", {31'h0, a}, {31'h0, ep});
  endtask : cmd

  task automatic rd(input logic [7:0] exp, input string what);
    logic [7:0] d;
    host.read(d);
    check(what, {24'h0, d}, {24'h0, exp});
  endtask : rd

  task automatic done_test(input string name);
    $display("test %s done, %0d mismatches so far", name, n_errors);
  endtask : done_test

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  initial
  begin
    #200000;
    n_errors++;
    $display("run limit reached");
    results();
  end

  initial
  begin
    rstn = 1'b0;
    busy_req = 1'b0;
    seq_done = 1'b0;
    seq_result = '0;
    seq_ptr_valid = 1'b0;
    seq_ptr_sel = bridge_ctl_pkg::SEL_CONDITION;
    codes = '{bridge_ctl_pkg::PTR_FEATURES, bridge_ctl_pkg::PTR_CONDITION,
              bridge_ctl_pkg::PTR_RECEIVED, bridge_ctl_pkg::PTR_PORT};
    sels = '{bridge_ctl_pkg::SEL_FEATURES, bridge_ctl_pkg::SEL_CONDITION,
             bridge_ctl_pkg::SEL_RECEIVED, bridge_ctl_pkg::SEL_PORT};
    repeat (8) @(posedge clock);
    #1;
    rstn = 1'b1;
    host.tick(6);
    check("features", 32'(features), 32'h0);
    check("port", port_timing, bridge_ctl_pkg::PORT_RESET);
    check("pointer", 32'(rd_ptr), 32'(bridge_ctl_pkg::SEL_CONDITION));
    rd(8'h10, "condition");
    done_test("power-on");
    cmd(bridge_ctl_pkg::CMD_WRITE_FEATURES, 8'h4A, 1'b1, 1'b0);
    check("features", 32'(features), 32'h0);
    rd(8'h10, "condition");
    done_test("bad complement");
    for (int i = 0; i < 4; i++)
    begin
      cmd(bridge_ctl_pkg::CMD_SET_POINTER, codes[i], 1'b1, 1'b1);
      check("pointer", 32'(rd_ptr), 32'(sels[i]));
    end
    for (int i = 0; i < 9; i++)
      rd(8'h06, "port code");
    cmd(bridge_ctl_pkg::CMD_SET_POINTER, 8'h55, 1'b1, 1'b0);
    check("pointer", 32'(rd_ptr), 32'(bridge_ctl_pkg::SEL_PORT));
    check("aborts", n_abort, 0);
    done_test("pointer");
    cmd(bridge_ctl_pkg::CMD_WRITE_FEATURES, 8'h5A, 1'b1, 1'b1);
    check("features", 32'(features), 32'hA);
    check("pointer", 32'(rd_ptr), 32'(bridge_ctl_pkg::SEL_FEATURES));
    check("port", port_timing, bridge_ctl_pkg::PORT_RESET);
    rd(8'h0A, "features read");
    cmd(bridge_ctl_pkg::CMD_SET_POINTER, bridge_ctl_pkg::PTR_CONDITION, 1'b1, 1'b1);
    rd(8'h00, "condition");
    done_test("feature write");
    busy_req = 1'b1;
    host.tick(2);
    rd(8'h01, "condition busy");
    cmd(bridge_ctl_pkg::CMD_WRITE_FEATURES, 8'hC3, 1'b0, 1'b0);
    check("features", 32'(features), 32'hA);
    for (int i = 0; i < 4; i++)
    begin
      seq_ptr_sel = sels[i];
      seq_ptr_valid = 1'b1;
      host.tick(1);
      seq_ptr_valid = 1'b0;
      host.tick(1);
      check("pointer", 32'(rd_ptr), 32'(sels[i]));
    end
    cmd(bridge_ctl_pkg::CMD_SET_POINTER, bridge_ctl_pkg::PTR_CONDITION, 1'b1, 1'b1);
    check("pointer", 32'(rd_ptr), 32'(bridge_ctl_pkg::SEL_CONDITION));
    seq_result = {5'h1F, 8'h3C};
    seq_done = 1'b1;
    host.tick(1);
    seq_done = 1'b0;
    // line idle before any further feature write
    busy_req = 1'b0;
    host.tick(2);
    rd(8'hE6, "condition result");
    cmd(bridge_ctl_pkg::CMD_SET_POINTER, bridge_ctl_pkg::PTR_RECEIVED, 1'b1, 1'b1);
    rd(8'h3C, "received");
    done_test("busy line");
    rstn = 1'b0;
    host.tick(2);
    rstn = 1'b1;
    host.tick(6);
    check("features", 32'(features), 32'h0);
    check("pointer", 32'(rd_ptr), 32'(bridge_ctl_pkg::SEL_CONDITION));
    rd(8'h10, "condition");
    done_test("mid-run reset");
    cmd(bridge_ctl_pkg::CMD_WRITE_FEATURES, 8'h3C, 1'b1, 1'b1);
    check("features", 32'(features), 32'hC);
    seq_result = {5'h15, 8'h81};
    seq_done = 1'b1;
    host.tick(1);
    seq_done = 1'b0;
    busy_req = 1'b1;
    host.tick(2);
    host.send(1'b1, bridge_ctl_pkg::CMD_GLOBAL_RESET, a);
    check("reset ack", {31'h0, a}, 32'h1);
    check("aborts", n_abort, 1);
    check("abort in time", {31'h0, abort_ns <= 262.5}, 32'h1);
    check("features", 32'(features), 32'h0);
    check("port", port_timing, bridge_ctl_pkg::PORT_RESET);
    check("pointer", 32'(rd_ptr), 32'(bridge_ctl_pkg::SEL_CONDITION));
    check("reset done", {31'h0, abort_ns + 160.0 <= 525.0}, 32'h1);
    rd(8'h10, "condition");
    done_test("global reset");
    results();
  end
endmodule : bridge_command_control_test
